// ---- src/tap_map.svh ----
// Register map, field positions, reset values and timing counts for the throttle alert block
`ifndef TAP_MAP_SVH
`define TAP_MAP_SVH

// ----------------------------------------------------------------------------
// Register offsets and reset values
// ----------------------------------------------------------------------------
`define TAP_ADDR_THRESH_DEG 8'h37
`define TAP_ADDR_SRC_EN 8'h38
`define TAP_RST_THRESH_DEG 8'h4a
`define TAP_RST_SRC_EN 8'ha0

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define TAP_OCT_MSB 7
`define TAP_OCT_LSB 3
`define TAP_DEG_MSB 2
`define TAP_DEG_LSB 1
`define TAP_RATIO_BIT 0
`define TAP_EN_VIN 7
`define TAP_EN_CMP 6
`define TAP_EN_CRIT 5
`define TAP_EN_NOM 4
`define TAP_EN_DCHG 3
`define TAP_EN_VSYS 2
`define TAP_EN_BATT 1
`define TAP_EN_ADPT 0
`define TAP_OCT_CODE_LOW 5'h00
`define TAP_OCT_CODE_HIGH 5'h1f

// ----------------------------------------------------------------------------
// Timing: times in ns, cycle counts derived from the clock rate
// ----------------------------------------------------------------------------
`define TAP_CLK_MHZ 250
`define TAP_CRIT_DEG0_NS 14500
`define TAP_CRIT_DEG1_NS 111000
`define TAP_CRIT_DEG2_NS 443000
`define TAP_CRIT_DEG3_NS 873000
`define TAP_CRIT_DEG0_CYC ((`TAP_CRIT_DEG0_NS * `TAP_CLK_MHZ) / 1000)
`define TAP_CRIT_DEG1_CYC ((`TAP_CRIT_DEG1_NS * `TAP_CLK_MHZ) / 1000)
`define TAP_CRIT_DEG2_CYC ((`TAP_CRIT_DEG2_NS * `TAP_CLK_MHZ) / 1000)
`define TAP_CRIT_DEG3_CYC ((`TAP_CRIT_DEG3_NS * `TAP_CLK_MHZ) / 1000)
`define TAP_BATT_PULSE_NS 10000
`define TAP_BATT_PULSE_CYC ((`TAP_BATT_PULSE_NS * `TAP_CLK_MHZ) / 1000)
`define TAP_DEG_CNT_W 18
`define TAP_PULSE_CNT_W 12

`endif

// ---- src/tap_pkg.sv ----
// Types shared by the throttle alert configuration block
package tap_pkg;

    // Threshold choice handed to the input-voltage alert comparator
    typedef enum logic [1:0] {
        TAP_VTH_FOLLOW,
        TAP_VTH_83PCT,
        TAP_VTH_91PCT
    } tap_vth_sel_e;

    typedef logic [7:0] tap_byte_t;

endpackage

// ---- src/tap_if.sv ----
// Interfaces joining the alert top to its deglitch and pulse helpers
`timescale 1ns/1ps

// ----------------------------------------------------------------------------
// Critical-current deglitch link
// ----------------------------------------------------------------------------
interface tap_deg_if;
    logic raw;
    logic [1:0] sel;
    logic qual;
    modport top (output raw, output sel, input qual);
    modport deg (input raw, input sel, output qual);
endinterface

// ----------------------------------------------------------------------------
// Battery-removal one-shot link
// ----------------------------------------------------------------------------
interface tap_pulse_if;
    logic trig;
    logic pulse;
    modport top (output trig, input pulse);
    modport gen (input trig, output pulse);
endinterface

// ---- src/tap_deglitch.sv ----
// Critical-current deglitch counter with selectable qualification time
`timescale 1ns/1ps
`include "tap_map.svh"

module tap_deglitch #(
    parameter int DEG0_CYC = `TAP_CRIT_DEG0_CYC,
    parameter int DEG1_CYC = `TAP_CRIT_DEG1_CYC,
    parameter int DEG2_CYC = `TAP_CRIT_DEG2_CYC,
    parameter int DEG3_CYC = `TAP_CRIT_DEG3_CYC
) (
    input wire logic core_clk,
    input wire logic rst_n,
    tap_deg_if.deg dg
);
    import tap_pkg::*;

    logic [`TAP_DEG_CNT_W-1:0] cnt_q;
    logic [`TAP_DEG_CNT_W-1:0] limit;
    logic qual_q;

    // Hold time chosen by the deglitch code
    always_comb begin
        case (dg.sel)
            2'h0: limit = `TAP_DEG_CNT_W'(DEG0_CYC);
            2'h1: limit = `TAP_DEG_CNT_W'(DEG1_CYC);
            2'h2: limit = `TAP_DEG_CNT_W'(DEG2_CYC);
            default: limit = `TAP_DEG_CNT_W'(DEG3_CYC);
        endcase
    end

    // Count while the raw condition holds; saturate so it never wraps
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= '0;
        end else if (!dg.raw) begin
            cnt_q <= '0;
        end else if (cnt_q < limit) begin
            cnt_q <= cnt_q + `TAP_DEG_CNT_W'(1);
        end
    end

    // Qualified once raw has held for the selected count of cycles
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            qual_q <= 1'b0;
        end else begin
            qual_q <= dg.raw && (cnt_q >= limit - `TAP_DEG_CNT_W'(1));
        end
    end

    assign dg.qual = qual_q;

    AST_DEG_DROP: assert property (@(posedge core_clk) disable iff (!rst_n)
        !dg.raw |=> !dg.qual)
        else $error("critical current qualified without raw condition");

    AST_DEG_NOT_EARLY: assert property (@(posedge core_clk) disable iff (!rst_n)
        $rose(dg.raw) |=> !dg.qual)
        else $error("critical current qualified without deglitch delay");

endmodule // tap_deglitch

// ---- src/tap_pulse.sv ----
// One-shot pulse generator for the battery-removal alert source
`timescale 1ns/1ps
`include "tap_map.svh"

module tap_pulse (
    input wire logic core_clk,
    input wire logic rst_n,
    tap_pulse_if.gen pg
);
    import tap_pkg::*;

    localparam logic [`TAP_PULSE_CNT_W-1:0] PulseLast = `TAP_PULSE_CNT_W'(`TAP_BATT_PULSE_CYC - 1);

    logic trig_q;
    logic pulse_q;
    logic [`TAP_PULSE_CNT_W-1:0] cnt_q;

    // Edge of the trigger starts one pulse; a held trigger gives no second one
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            trig_q <= 1'b0;
            pulse_q <= 1'b0;
            cnt_q <= '0;
        end else begin
            trig_q <= pg.trig;
            if (pg.trig && !trig_q && !pulse_q) begin
                pulse_q <= 1'b1;
                cnt_q <= '0;
            end else if (pulse_q) begin
                if (cnt_q == PulseLast) begin
                    pulse_q <= 1'b0;
                end
                cnt_q <= cnt_q + `TAP_PULSE_CNT_W'(1);
            end
        end
    end

    assign pg.pulse = pulse_q;

    AST_PULSE_START: assert property (@(posedge core_clk) disable iff (!rst_n)
        (pg.trig && !trig_q && !pulse_q) |=> pg.pulse)
        else $error("battery removal did not start a pulse");

    AST_PULSE_ENDS: assert property (@(posedge core_clk) disable iff (!rst_n)
        (pulse_q && cnt_q == PulseLast) |=> !pg.pulse)
        else $error("battery removal pulse did not end");

endmodule // tap_pulse

// ---- src/tap_alert_cfg.sv ----
// Throttle alert profile registers and alert output logic
//
// Contract
// - Critical current deglitched by 2-bit time code
// - Ratio bit picks 83% or 91% threshold
// - Reduced enable clear: threshold follows voltage limit
// - Bit 7 enables input-voltage-limit alert source
// - Bit 6 enables compensation alert source
// - Bit 5 enables critical current alert source
// - Bit 4 enables nominal current alert source
// - Bit 3 enables discharge level-one alert source
// - Bit 2 enables low system voltage source
// - Battery removal gives one-shot alert pulse
// - Adapter removal pulls alert low when enabled
// - Register reset restores both registers' defaults
`timescale 1ns/1ps
`include "tap_map.svh"

module tap_alert_cfg #(
    parameter int CRIT_DEG1_CYC = `TAP_CRIT_DEG1_CYC,
    parameter int CRIT_DEG2_CYC = `TAP_CRIT_DEG2_CYC,
    parameter int CRIT_DEG3_CYC = `TAP_CRIT_DEG3_CYC
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [7:0] reg_addr,
    input wire tap_pkg::tap_byte_t reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output tap_pkg::tap_byte_t reg_rdata,
    output logic reg_rvalid,
    input wire logic reg_reset_cmd,
    input wire logic reduced_vin_limit_enable,
    input wire logic vin_limit_cond,
    input wire logic comp_cond,
    input wire logic crit_current_raw,
    input wire logic nominal_current_cond,
    input wire logic discharge1_cond,
    input wire logic sys_voltage_cond,
    input wire logic battery_present,
    input wire logic adapter_present,
    output logic [4:0] secondary_overcurrent_threshold,
    output logic oct_code_out_of_range,
    output tap_pkg::tap_vth_sel_e vin_thresh_sel,
    output logic throttle_alert_n
);
    import tap_pkg::*;

    // ------------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------------
    tap_byte_t thresh_deg_q;
    tap_byte_t src_en_q;
    tap_byte_t rdata_q;
    logic rvalid_q;
    logic [4:0] oct_q;
    logic oct_bad_q;
    tap_vth_sel_e vth_q;
    logic alert_n_q;
    logic [7:0] src_cond;
    logic [7:0] src_active;
    logic wr_thresh;
    logic wr_src;

    tap_deg_if deg_bus ();
    tap_pulse_if pulse_bus ();

    assign wr_thresh = reg_wr && (reg_addr == `TAP_ADDR_THRESH_DEG);
    assign wr_src = reg_wr && (reg_addr == `TAP_ADDR_SRC_EN);

    // ------------------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------------------

    // Threshold/deglitch/ratio register; reset command beats a same-cycle write
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            thresh_deg_q <= `TAP_RST_THRESH_DEG;
        end else if (reg_reset_cmd) begin
            thresh_deg_q <= `TAP_RST_THRESH_DEG;
        end else if (wr_thresh) begin
            thresh_deg_q <= reg_wdata;
        end
    end

    // Source enable register
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            src_en_q <= `TAP_RST_SRC_EN;
        end else if (reg_reset_cmd) begin
            src_en_q <= `TAP_RST_SRC_EN;
        end else if (wr_src) begin
            src_en_q <= reg_wdata;
        end
    end

    // Read port: one cycle latency, unmapped offsets read zero
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= '0;
            rvalid_q <= 1'b0;
        end else begin
            rvalid_q <= reg_rd;
            if (reg_rd) begin
                case (reg_addr)
                    `TAP_ADDR_THRESH_DEG: rdata_q <= thresh_deg_q;
                    `TAP_ADDR_SRC_EN: rdata_q <= src_en_q;
                    default: rdata_q <= '0;
                endcase
            end
        end
    end

    assign reg_rdata = rdata_q;
    assign reg_rvalid = rvalid_q;

    // ------------------------------------------------------------------------
    // Configuration outputs to the analog side
    // ------------------------------------------------------------------------

    // Threshold code and its range flag; an out-of-range code is passed on
    // unchanged, since clamping would hide a host mistake from the comparator
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            oct_q <= 5'(`TAP_RST_THRESH_DEG >> `TAP_OCT_LSB);
            oct_bad_q <= 1'b0;
        end else begin
            oct_q <= thresh_deg_q[`TAP_OCT_MSB:`TAP_OCT_LSB];
            oct_bad_q <= (thresh_deg_q[`TAP_OCT_MSB:`TAP_OCT_LSB] == `TAP_OCT_CODE_LOW) ||
                         (thresh_deg_q[`TAP_OCT_MSB:`TAP_OCT_LSB] == `TAP_OCT_CODE_HIGH);
        end
    end

    // Comparator threshold choice
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            vth_q <= TAP_VTH_FOLLOW;
        end else if (!reduced_vin_limit_enable) begin
            vth_q <= TAP_VTH_FOLLOW;
        end else if (thresh_deg_q[`TAP_RATIO_BIT]) begin
            vth_q <= TAP_VTH_91PCT;
        end else begin
            vth_q <= TAP_VTH_83PCT;
        end
    end

    assign secondary_overcurrent_threshold = oct_q;
    assign oct_code_out_of_range = oct_bad_q;
    assign vin_thresh_sel = vth_q;

    // ------------------------------------------------------------------------
    // Alert sources
    // ------------------------------------------------------------------------

    // Critical current goes through the deglitch before it may alert
    assign deg_bus.raw = crit_current_raw;
    assign deg_bus.sel = thresh_deg_q[`TAP_DEG_MSB:`TAP_DEG_LSB];

    tap_deglitch #(
        .DEG0_CYC(`TAP_CRIT_DEG0_CYC),
        .DEG1_CYC(CRIT_DEG1_CYC),
        .DEG2_CYC(CRIT_DEG2_CYC),
        .DEG3_CYC(CRIT_DEG3_CYC)
    ) u_deglitch (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .dg(deg_bus)
    );

    // Battery removal only while enabled; enabling with the battery already
    // out also fires, as the trigger rises then
    assign pulse_bus.trig = src_en_q[`TAP_EN_BATT] && !battery_present;

    tap_pulse u_pulse (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .pg(pulse_bus)
    );

    // Condition vector laid out like the enable register
    assign src_cond = {vin_limit_cond, comp_cond, deg_bus.qual, nominal_current_cond,
                       discharge1_cond, sys_voltage_cond, pulse_bus.pulse,
                       !adapter_present};

    // Per-bit gating of each source by its enable
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_src
            assign src_active[gi] = src_en_q[gi] && src_cond[gi];
        end
    endgenerate

    // Active-low alert, registered so the pin never glitches
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            alert_n_q <= 1'b1;
        end else begin
            alert_n_q <= ~(|src_active);
        end
    end

    assign throttle_alert_n = alert_n_q;

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);

    AST_OCT_FIELD: assert property (
        wr_thresh && !reg_reset_cmd |=> ##1 secondary_overcurrent_threshold == $past(reg_wdata[7:3], 2))
        else $error("threshold field output does not follow write");

    AST_DEG_SEL: assert property (
        wr_thresh && !reg_reset_cmd |=> deg_bus.sel == $past(reg_wdata[2:1]))
        else $error("deglitch select does not follow write");

    AST_RATIO: assert property (
        reduced_vin_limit_enable |=> vin_thresh_sel == ($past(thresh_deg_q[0]) ? TAP_VTH_91PCT : TAP_VTH_83PCT))
        else $error("reduced threshold ratio wrong");

    AST_FOLLOW: assert property (
        !reduced_vin_limit_enable |=> vin_thresh_sel == TAP_VTH_FOLLOW)
        else $error("threshold does not follow voltage limit");

    AST_VIN_SRC: assert property (
        src_en_q[7] && vin_limit_cond |=> !throttle_alert_n)
        else $error("voltage limit source did not alert");

    AST_CMP_SRC: assert property (
        src_en_q[6] && comp_cond |=> !throttle_alert_n)
        else $error("compensation source did not alert");

    AST_CRIT_SRC: assert property (
        src_en_q[5] && deg_bus.qual |=> !throttle_alert_n)
        else $error("critical current source did not alert");

    AST_NOM_SRC: assert property (
        src_en_q[4] && nominal_current_cond |=> !throttle_alert_n)
        else $error("nominal current source did not alert");

    AST_DCHG_SRC: assert property (
        src_en_q[3] && discharge1_cond |=> !throttle_alert_n)
        else $error("discharge source did not alert");

    AST_VSYS_SRC: assert property (
        src_en_q[2] && sys_voltage_cond |=> !throttle_alert_n)
        else $error("system voltage source did not alert");

    AST_BATT_SRC: assert property (
        src_en_q[1] && battery_present ##1 src_en_q[1] && !battery_present |=> ##1 !throttle_alert_n)
        else $error("battery removal did not pulse the alert");

    AST_ADPT_SRC: assert property (
        src_en_q[0] && !adapter_present |=> !throttle_alert_n)
        else $error("adapter removal did not pull alert low");

    AST_REG_RESET: assert property (
        reg_reset_cmd |=> thresh_deg_q == `TAP_RST_THRESH_DEG && src_en_q == `TAP_RST_SRC_EN)
        else $error("register reset did not restore defaults");

    AST_IDLE_HIGH: assert property (
        src_active == 8'h00 |=> throttle_alert_n)
        else $error("alert asserted with no enabled source");

    AST_READ_LAT: assert property (
        reg_rd && reg_addr == `TAP_ADDR_SRC_EN && !reg_wr && !reg_reset_cmd
            |=> reg_rvalid && reg_rdata == $past(src_en_q))
        else $error("read of enable register wrong");

    // Range flag and field copy come from the same register sample
    AST_OOR_FLAG: assert property (
        oct_code_out_of_range == (secondary_overcurrent_threshold == `TAP_OCT_CODE_LOW ||
            secondary_overcurrent_threshold == `TAP_OCT_CODE_HIGH))
        else $error("threshold range flag disagrees with field");

    AST_THRESH_WRITE: assert property (
        wr_thresh && !reg_reset_cmd |=> thresh_deg_q == $past(reg_wdata))
        else $error("threshold register did not take write");

    AST_SRC_WRITE: assert property (
        wr_src && !reg_reset_cmd |=> src_en_q == $past(reg_wdata))
        else $error("enable register did not take write");

    // Writes to unmapped offsets must not disturb either register
    AST_UNMAPPED_WRITE: assert property (
        reg_wr && !wr_thresh && !wr_src && !reg_reset_cmd
            |=> $stable(thresh_deg_q) && $stable(src_en_q))
        else $error("unmapped write changed a register");

    AST_UNMAPPED_READ: assert property (
        reg_rd && reg_addr != `TAP_ADDR_THRESH_DEG && reg_addr != `TAP_ADDR_SRC_EN
            |=> reg_rvalid && reg_rdata == 8'h00)
        else $error("unmapped read did not return zero");

    AST_READ_THRESH: assert property (
        reg_rd && reg_addr == `TAP_ADDR_THRESH_DEG |=> reg_rvalid && reg_rdata == $past(thresh_deg_q))
        else $error("read of threshold register wrong");

    AST_NO_RVALID: assert property (
        !reg_rd |=> !reg_rvalid)
        else $error("read valid without a read strobe");

endmodule // tap_alert_cfg

// ---- sim/tap_cpu_model.sv ----
// Behavioural CPU throttle input that counts alert pulses and low-run lengths
`timescale 1ns/1ps

module tap_cpu_model (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic throttle_alert_n,
    output int pulses,
    output int last_len
);
    int run_q;
    logic prev_q;

    // ------------------------------------------------------------------------
    // Alert watcher
    // ------------------------------------------------------------------------
    // Active low line; a run is closed only when the line returns high
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pulses <= 0;
            last_len <= 0;
            run_q <= 0;
            prev_q <= 1'b1;
        end else begin
            prev_q <= throttle_alert_n;
            if (!throttle_alert_n) begin
                run_q <= run_q + 1;
            end else if (!prev_q) begin
                last_len <= run_q;
                run_q <= 0;
            end
            if (prev_q && !throttle_alert_n) begin
                pulses <= pulses + 1;
            end
        end
    end
endmodule // tap_cpu_model

// ---- sim/throttle_alert_profile_config_tb_top.sv ----
// Self-checking bench for the throttle alert profile registers and alert output
`timescale 1ns/1ps
`include "tap_map.svh"

module throttle_alert_profile_config_tb_top;
    import tap_pkg::*;
    // Short deglitch counts keep the run brief; code 0 stays at its fixed count
    localparam int DEG1 = 20;
    localparam int DEG2 = 40;
    localparam int DEG3 = 80;
    localparam int PULSE_CYC = 2500;
    int degtab [4] = '{`TAP_CRIT_DEG0_CYC, DEG1, DEG2, DEG3};
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    tap_byte_t reg_wdata = 8'h00;
    logic reg_wr = 1'b0, reg_rd = 1'b0, reg_reset_cmd = 1'b0;
    logic reduced_vin_limit_enable = 1'b0, vin_limit_cond = 1'b0, comp_cond = 1'b0;
    logic crit_current_raw = 1'b0, nominal_current_cond = 1'b0, discharge1_cond = 1'b0;
    logic sys_voltage_cond = 1'b0, battery_present = 1'b1, adapter_present = 1'b1;
    tap_byte_t reg_rdata;
    logic reg_rvalid, oor, alert_n;
    logic [4:0] sot;
    tap_vth_sel_e vsel;
    int cpu_pulses, cpu_len, base, code;
    int num_errors = 0;
    int n_compared = 0;
    int m37 = 'h4a;
    int m38 = 'ha0;

    always #2 core_clk = ~core_clk;

    tap_alert_cfg #(.CRIT_DEG1_CYC(DEG1), .CRIT_DEG2_CYC(DEG2), .CRIT_DEG3_CYC(DEG3)) dut (
        .core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .reg_reset_cmd(reg_reset_cmd), .reduced_vin_limit_enable(reduced_vin_limit_enable),
        .vin_limit_cond(vin_limit_cond), .comp_cond(comp_cond),
        .crit_current_raw(crit_current_raw), .nominal_current_cond(nominal_current_cond),
        .discharge1_cond(discharge1_cond), .sys_voltage_cond(sys_voltage_cond),
        .battery_present(battery_present), .adapter_present(adapter_present),
        .secondary_overcurrent_threshold(sot), .oct_code_out_of_range(oor),
        .vin_thresh_sel(vsel), .throttle_alert_n(alert_n));

    tap_cpu_model cpu (.core_clk(core_clk), .rst_n(rst_n), .throttle_alert_n(alert_n),
        .pulses(cpu_pulses), .last_len(cpu_len));

    // ------------------------------------------------------------------------
    // Shared tasks and the reference model
    // ------------------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD t=%0t %s got %0h exp %0h", $time, what, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge core_clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge core_clk);
        reg_wr = 1'b0;
        if (a == `TAP_ADDR_THRESH_DEG) m37 = d;
        if (a == `TAP_ADDR_SRC_EN) m38 = d;
    endtask

    // Read strobe for one cycle; the answer stands for the cycle after
    task automatic rd(input logic [7:0] a);
        int e;
        e = (a == `TAP_ADDR_THRESH_DEG) ? m37 : (a == `TAP_ADDR_SRC_EN) ? m38 : 0;
        @(negedge core_clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge core_clk);
        reg_rd = 1'b0;
        chk(reg_rvalid, 1, "rvalid");
        chk(reg_rdata, e, "rdata");
    endtask

    // Alert level from enables and plain level conditions (critical and battery idle)
    function automatic logic exp_alert_n();
        int cv;
        cv = {vin_limit_cond, comp_cond, 1'b0, nominal_current_cond, discharge1_cond,
              sys_voltage_cond, 1'b0, !adapter_present};
        return !((m38 & cv) != 0);
    endfunction

    task automatic tally_and_finish();
        $display("Compared %0d, errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Hang guard, well beyond the roughly 10000 cycles the sequence needs
    initial begin
        #(4 * 60000);
        num_errors++;
        tally_and_finish();
    end

    // ------------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------------
    initial begin
        void'($urandom(32'hee5c3533));
        repeat (8) @(posedge core_clk);
        @(negedge core_clk);
        rst_n = 1'b1;
        rd(`TAP_ADDR_THRESH_DEG);
        rd(`TAP_ADDR_SRC_EN);
        wr(8'h39, 8'($urandom));
        rd(8'h39);
        rd(`TAP_ADDR_SRC_EN);
        chk(sot, 9, "threshold reset");
        chk(vsel, TAP_VTH_FOLLOW, "follow at reset");
        chk(alert_n, 1, "alert idle");
        // Threshold field including both out-of-range codes
        for (int i = 0; i < 6; i++) begin
            code = (i == 0) ? 0 : (i == 1) ? 31 : (i == 2) ? 1 : (i == 3) ? 30 : 0;
            if (i > 3) code = 1 + $urandom_range(29);
            wr(`TAP_ADDR_THRESH_DEG, {5'(code), 3'b010});
            @(negedge core_clk);
            chk(sot, code, "threshold");
            chk(oor, (code == 0 || code == 31), "range flag");
        end
        // Comparator threshold choice over reduced enable and ratio bit
        for (int i = 0; i < 4; i++) begin
            reduced_vin_limit_enable = i[1];
            wr(`TAP_ADDR_THRESH_DEG, {5'h09, 2'b01, i[0]});
            @(negedge core_clk);
            chk(vsel, !i[1] ? TAP_VTH_FOLLOW : i[0] ? TAP_VTH_91PCT : TAP_VTH_83PCT, "vth");
        end
        reduced_vin_limit_enable = 1'b0;
        // Random enables against random level conditions
        for (int k = 0; k < 24; k++) begin
            wr(`TAP_ADDR_SRC_EN, 8'($urandom) & 8'hdd);
            {vin_limit_cond, comp_cond, nominal_current_cond, discharge1_cond,
             sys_voltage_cond} = 5'($urandom);
            adapter_present = 1'($urandom);
            @(negedge core_clk);
            chk(alert_n, exp_alert_n(), "alert level");
            rd(`TAP_ADDR_SRC_EN);
        end
        {vin_limit_cond, comp_cond, nominal_current_cond, discharge1_cond} = 4'h0;
        sys_voltage_cond = 1'b0;
        adapter_present = 1'b1;
        // Critical current with every deglitch code
        wr(`TAP_ADDR_SRC_EN, 8'h20);
        for (int c = 0; c < 4; c++) begin
            wr(`TAP_ADDR_THRESH_DEG, 8'h48 | 8'(c << 1));
            crit_current_raw = 1'b1;
            // Qualified on the last of N raw samples, alert one edge later
            repeat (degtab[c]) @(negedge core_clk);
            chk(alert_n, 1, "crit early");
            @(negedge core_clk);
            chk(alert_n, 0, "crit qualified");
            crit_current_raw = 1'b0;
            repeat (2) @(negedge core_clk);
            chk(alert_n, 1, "crit released");
        end
        // A one-cycle drop restarts the qualification count
        wr(`TAP_ADDR_THRESH_DEG, 8'h4a);
        crit_current_raw = 1'b1;
        repeat (DEG1 - 1) @(negedge core_clk);
        crit_current_raw = 1'b0;
        @(negedge core_clk);
        crit_current_raw = 1'b1;
        repeat (DEG1) @(negedge core_clk);
        chk(alert_n, 1, "crit restart");
        @(negedge core_clk);
        chk(alert_n, 0, "crit after restart");
        crit_current_raw = 1'b0;
        // Battery removal: one pulse of fixed width, none when disabled
        wr(`TAP_ADDR_SRC_EN, 8'h02);
        base = cpu_pulses;
        battery_present = 1'b0;
        repeat (6000) @(negedge core_clk);
        chk(cpu_pulses - base, 1, "one pulse");
        chk(cpu_len, PULSE_CYC, "pulse width");
        battery_present = 1'b1;
        wr(`TAP_ADDR_SRC_EN, 8'h00);
        battery_present = 1'b0;
        repeat (50) @(negedge core_clk);
        chk(cpu_pulses - base, 1, "disabled battery");
        battery_present = 1'b1;
        // Register reset wins over a write in the same cycle
        wr(`TAP_ADDR_THRESH_DEG, {5'(1 + $urandom_range(29)), 3'($urandom)});
        wr(`TAP_ADDR_SRC_EN, 8'($urandom));
        @(negedge core_clk);
        reg_addr = `TAP_ADDR_SRC_EN;
        reg_wdata = 8'h5f;
        reg_wr = 1'b1;
        reg_reset_cmd = 1'b1;
        @(negedge core_clk);
        reg_wr = 1'b0;
        reg_reset_cmd = 1'b0;
        m37 = 'h4a;
        m38 = 'ha0;
        rd(`TAP_ADDR_THRESH_DEG);
        rd(`TAP_ADDR_SRC_EN);
        chk(sot, 9, "threshold after reset cmd");
        tally_and_finish();
    end
endmodule // throttle_alert_profile_config_tb_top
